// ---- rtl/fsplc_map.vh ----
// constants for the flash self-program and lock controller
`ifndef FSPLC_MAP_VH
`define FSPLC_MAP_VH
`define FSPLC_CTRL_OFS 8'h57
`define FSPLC_CTRL_RST 8'h00
`define FSPLC_B_EN 0
`define FSPLC_B_ERS 1
`define FSPLC_B_WRT 2
`define FSPLC_B_LCK 3
`define FSPLC_B_REN 4
`define FSPLC_B_BUSY 6
`define FSPLC_CMD_FILL 5'h01
`define FSPLC_CMD_ERS 5'h03
`define FSPLC_CMD_WRT 5'h05
`define FSPLC_CMD_LCK 5'h09
`define FSPLC_CMD_REN 5'h11
`define FSPLC_ARM_CYC 3'h4
`define FSPLC_LOCK_RST 8'hff
`define FSPLC_PAGE_WORDS 128
`define FSPLC_OP_TIME_NS 32'd4000
`define FSPLC_CLK_NS 32'd10
`define FSPLC_OP_CYC (`FSPLC_OP_TIME_NS / `FSPLC_CLK_NS)
`define FSPLC_FUSE_RST 24'hffffff
`endif

// ---- rtl/fsplc_ctrl.v ----
// flash self-program sequencer with lock-bit access checks
`timescale 1ns/10ps
`include "fsplc_map.vh"
// Notes on behaviour
// - armed page write runs on store within four
// - page from pointer high bits, data ignored
// - write command clears on completion or lapse
// - stall cpu while no-read-while-write page busy
// - armed page erase runs on store within four
// - erase command clears on completion or lapse
// - store enable arms store for four cycles
// - plain store fills buffer word from data pair
// - store enable self-clears; held during operation
// - only five legal low-bit patterns take effect
// - lock bits return to one only by chip erase or reset
// - lock byte layout, one means unprogrammed
// - memory lock 10 refuses external programming
// - memory lock 00 refuses program and verify
// - app pair 10 blocks stores into app
// - app pair 00 blocks stores and boot loads
// - app pair 01 blocks boot loads only
// - app modes 00/01 mask interrupts in app when vectors are in boot
// - boot pair mirrors app pair rules
// - boot modes 00/01 mask interrupts in boot when vectors are in app
// - three fuse bytes, programmed reads zero
// - armed lock set writes lock bits from low data
// - rww operation sets busy, region unreadable
// - 128 word page, word index zero on write
module fsplc_ctrl (
  input wire sys_clk,
  input wire nrst,
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  output wire [7:0] ctrl_rdata,
  input wire store_req,
  input wire [15:0] store_ptr,
  input wire [7:0] data_word_low_reg,
  input wire [7:0] data_word_high_reg,
  input wire load_req,
  input wire [15:0] load_ptr,
  input wire [15:0] exec_pc,
  input wire [15:0] boot_start,
  input wire vectors_in_boot,
  input wire chip_erase,
  input wire ext_prog_req,
  input wire ext_verify_req,
  input wire ext_fuse_req,
  input wire ext_boot_lock_req,
  output wire store_blocked,
  output wire load_blocked,
  output wire rww_read_blocked,
  output wire cpu_stall,
  output wire irq_mask,
  output wire ext_prog_refused,
  output wire ext_verify_refused,
  output wire ext_fuse_locked,
  output wire ext_boot_lock_locked,
  output reg [7:0] lock_byte_r,
  output reg [23:0] fuse_bytes_r,
  output reg flash_op_r,
  output reg flash_op_erase_r,
  output reg [8:0] flash_page_r,
  output reg [15:0] buf_rd_data_r,
  input wire [6:0] buf_rd_idx
);

localparam ST_IDLE = 2'd0;
localparam ST_ARMED = 2'd1;
localparam ST_BUSY = 2'd2;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [4:0] cmd_r;
reg [2:0] arm_cnt_r;
reg [15:0] op_cnt_r;
reg busy_rww_r;
reg op_no_read_while_write_region_r;
reg [15:0] page_buf [0:`FSPLC_PAGE_WORDS-1];
reg [`FSPLC_PAGE_WORDS-1:0] buf_vld_r;

////////////////////////////////////////////////////////////////////////////
// lock decode
wire [1:0] mem_lock = lock_byte_r[1:0];
wire [1:0] app_lock = lock_byte_r[3:2];
wire [1:0] boot_lock = lock_byte_r[5:4];
// pointers are byte addresses, boot_start is a word address
wire tgt_boot = {1'b0, store_ptr[15:1]} >= boot_start;
wire ld_boot = {1'b0, load_ptr[15:1]} >= boot_start;
wire pc_boot = exec_pc >= boot_start;

// stores: pairs 10 and 00 forbid writing the section
assign store_blocked = tgt_boot ? ~boot_lock[0] : ~app_lock[0];
// loads across sections: pairs 00 and 01 forbid it
assign load_blocked = load_req & (
  (pc_boot & ~ld_boot & ~app_lock[1]) |
  (~pc_boot & ld_boot & ~boot_lock[1]));
assign irq_mask = (~pc_boot & vectors_in_boot & ~app_lock[1]) |
  (pc_boot & ~vectors_in_boot & ~boot_lock[1]);
assign ext_prog_refused = ext_prog_req & ~mem_lock[0];
assign ext_fuse_locked = ext_fuse_req & ~mem_lock[0];
assign ext_verify_refused = ext_verify_req & (mem_lock == 2'b00);
assign ext_boot_lock_locked = ext_boot_lock_req & (mem_lock == 2'b00);
assign rww_read_blocked = busy_rww_r & load_req & ~ld_boot;

////////////////////////////////////////////////////////////////////////////
// command sequencing
wire legal = (ctrl_wdata[4:0] == `FSPLC_CMD_FILL) | (ctrl_wdata[4:0] == `FSPLC_CMD_ERS) |
  (ctrl_wdata[4:0] == `FSPLC_CMD_WRT) | (ctrl_wdata[4:0] == `FSPLC_CMD_LCK) |
  (ctrl_wdata[4:0] == `FSPLC_CMD_REN);
wire arm_now = ctrl_wr & legal & (state_r == ST_IDLE);
wire fire = (state_r == ST_ARMED) & store_req;
wire lapse = (state_r == ST_ARMED) & ~store_req & (arm_cnt_r == `FSPLC_ARM_CYC - 3'h1);
wire is_pg = (cmd_r == `FSPLC_CMD_ERS) | (cmd_r == `FSPLC_CMD_WRT);
// a page op into a locked section is dropped before it starts
wire pg_ok = fire & is_pg & ~store_blocked;
wire fill_ok = fire & (cmd_r == `FSPLC_CMD_FILL) & ~store_blocked;
wire op_done = (state_r == ST_BUSY) & (op_cnt_r == 16'h0001);
wire [31:0] op_cyc_full = `FSPLC_OP_CYC;

always @* begin
  state_nxt = state_r;
  case (state_r)
    ST_IDLE: begin
      if (arm_now)
        state_nxt = ST_ARMED;
    end
    ST_ARMED: begin
      if (pg_ok)
        state_nxt = ST_BUSY;
      else if (fire || lapse)
        state_nxt = ST_IDLE;
    end
    ST_BUSY: begin
      if (op_done)
        state_nxt = ST_IDLE;
    end
    default: state_nxt = ST_IDLE;
  endcase
end

always @(posedge sys_clk) begin
  if (!nrst) begin
    state_r <= ST_IDLE;
    cmd_r <= 5'h00;
    arm_cnt_r <= 3'h0;
    op_cnt_r <= 16'h0000;
    busy_rww_r <= 1'b0;
    op_no_read_while_write_region_r <= 1'b0;
    flash_op_r <= 1'b0;
    flash_op_erase_r <= 1'b0;
    flash_page_r <= 9'h000;
  end else begin
    state_r <= state_nxt;
    flash_op_r <= 1'b0;
    if (arm_now) begin
      cmd_r <= ctrl_wdata[4:0];
      arm_cnt_r <= 3'h0;
    end else if (state_r == ST_ARMED) begin
      arm_cnt_r <= arm_cnt_r + 3'h1;
    end
    if (state_nxt == ST_IDLE)
      cmd_r <= 5'h00;
    if (pg_ok) begin
      op_cnt_r <= op_cyc_full[15:0];
      // bit 0 byte, 7:1 buffer word, 15:8 page
      flash_page_r <= {1'b0, store_ptr[15:8]};
      op_no_read_while_write_region_r <= tgt_boot;
      flash_op_erase_r <= (cmd_r == `FSPLC_CMD_ERS);
      if (!tgt_boot)
        busy_rww_r <= 1'b1;
    end else if (state_r == ST_BUSY) begin
      op_cnt_r <= op_cnt_r - 16'h0001;
      flash_op_r <= op_done; // commit pulse at the end
    end
    // re-enable only takes while the flash is idle
    if (fire && cmd_r == `FSPLC_CMD_REN)
      busy_rww_r <= 1'b0;
    else if (fill_ok)
      busy_rww_r <= 1'b0;
  end
end

assign cpu_stall = (state_r == ST_BUSY) & op_no_read_while_write_region_r;

////////////////////////////////////////////////////////////////////////////
// page buffer; write commits clear it for the next fill
always @(posedge sys_clk) begin
  if (fill_ok)
    page_buf[store_ptr[7:1]] <= {data_word_high_reg, data_word_low_reg};
  buf_rd_data_r <= buf_vld_r[buf_rd_idx] ? page_buf[buf_rd_idx] : 16'hffff;
end

always @(posedge sys_clk) begin
  if (!nrst)
    buf_vld_r <= {`FSPLC_PAGE_WORDS{1'b0}};
  else if (op_done && !flash_op_erase_r)
    buf_vld_r <= {`FSPLC_PAGE_WORDS{1'b0}};
  else if (fill_ok)
    buf_vld_r[store_ptr[7:1]] <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////
// lock and fuse storage
always @(posedge sys_clk) begin
  if (!nrst) begin
    lock_byte_r <= `FSPLC_LOCK_RST;
    fuse_bytes_r <= `FSPLC_FUSE_RST;
  end else if (chip_erase) begin
    lock_byte_r <= `FSPLC_LOCK_RST;
  end else if (fire && cmd_r == `FSPLC_CMD_LCK) begin
    // only programs bits toward zero
    lock_byte_r <= lock_byte_r & {2'b11, data_word_low_reg[5:0]};
  end
end

assign ctrl_rdata = {1'b0, busy_rww_r, 1'b0, cmd_r};

endmodule

// ---- dv/fsplc_ctrl_properties.sv ----
// concurrent checks on the flash self-program and lock controller ports
`timescale 1ns/10ps
module fsplc_ctrl_properties (
  input wire sys_clk,
  input wire nrst,
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  input wire [7:0] ctrl_rdata,
  input wire store_req,
  input wire store_blocked,
  input wire cpu_stall,
  input wire chip_erase,
  input wire ext_prog_refused,
  input wire ext_verify_refused,
  input wire [7:0] lock_byte_r,
  input wire flash_op_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire [4:0] cmd = ctrl_rdata[4:0];
  wire [4:0] wc = ctrl_wdata[4:0];
  wire idle = cmd == 5'h00;
  wire legal = wc == 5'h01 || wc == 5'h03 || wc == 5'h05 || wc == 5'h09 || wc == 5'h11;
  wire page_cmd = cmd == 5'h03 || cmd == 5'h05;
  wire ext_ok = ext_prog_refused == !lock_byte_r[0]
    && ext_verify_refused == (lock_byte_r[1:0] == 2'b00);
  sequence arm_s; ctrl_wr && legal && idle; endsequence
  sequence quiet_s; !store_req [*4]; endsequence
  sequence op_start_s; page_cmd && store_req && !store_blocked; endsequence
  chk_arm_lapse: assert property (arm_s ##1 quiet_s |=> idle)
    else $error("arming did not lapse");
  chk_cmd_taken: assert property (arm_s |=> cmd == $past(ctrl_wdata[4:0]))
    else $error("legal command not held");
  chk_bad_ignored: assert property (ctrl_wr && !legal && idle |=> idle)
    else $error("illegal command acted");
  chk_op_time: assert property (op_start_s |-> ##[395:405] flash_op_r)
    else $error("page operation did not end");
  chk_op_clears: assert property (flash_op_r |=> idle)
    else $error("command kept after operation");
  chk_stall_hold: assert property ($rose(cpu_stall) |-> (cpu_stall && page_cmd) [*8])
    else $error("stall or enable dropped early");
  chk_lock_mono: assert property (!chip_erase |=> (lock_byte_r & ~$past(lock_byte_r)) == 8'h00)
    else $error("lock bit returned to one");
  chk_ext_lock: assert property (ext_ok)
    else $error("external refusal wrong");
endmodule
bind fsplc_ctrl fsplc_ctrl_properties u_props (.sys_clk(sys_clk), .nrst(nrst),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .store_req(store_req),
  .store_blocked(store_blocked), .cpu_stall(cpu_stall), .chip_erase(chip_erase),
  .ext_prog_refused(ext_prog_refused), .ext_verify_refused(ext_verify_refused),
  .lock_byte_r(lock_byte_r), .flash_op_r(flash_op_r));

// ---- dv/fsplc_cpu_model.sv ----
// processor side model issuing flash store instructions
`timescale 1ns/10ps
module fsplc_cpu_model (
  input wire sys_clk,
  output logic store_req,
  output logic [15:0] store_ptr,
  output logic [7:0] data_word_low_reg,
  output logic [7:0] data_word_high_reg
);
  initial begin
    store_req = 1'b0;
    store_ptr = 16'h0000;
    {data_word_high_reg, data_word_low_reg} = 16'h0000;
  end
  // pointer and data pair hold afterwards, as core registers would
  task store(input logic [15:0] ptr, input logic [15:0] word, input logic req);
    store_ptr = ptr;
    {data_word_high_reg, data_word_low_reg} = word;
    store_req = req;
    @(posedge sys_clk);
    #1;
    store_req = 1'b0;
  endtask
endmodule

// ---- dv/fsplc_ctrl_bench.sv ----
// self-checking bench for the flash self-program and lock controller
`timescale 1ns/10ps
module fsplc_ctrl_bench;
  logic sys_clk = 1'b0, nrst = 1'b0, ctrl_wr = 1'b0, load_req = 1'b0, ce = 1'b0;
  logic [7:0] wd = 8'h00, seed = 8'd73;
  logic [7:0] cmds [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
  logic [15:0] lptr = 16'h0000, pc = 16'h0000, word;
  logic [6:0] idx = 7'h00;
  logic vib = 1'b1;
  wire ers, rrb, efl, ebl;
  wire [8:0] pg;
  int n_mismatch = 0, compares = 0;
  wire [7:0] rd, lb, dlo, dhi;
  wire [15:0] sptr, bufd;
  wire [23:0] fuse;
  wire sreq, sblk, lblk, stall, irqm, epr, evr, op;
  always #5 sys_clk = ~sys_clk;
  fsplc_cpu_model m (.sys_clk(sys_clk), .store_req(sreq), .store_ptr(sptr),
    .data_word_low_reg(dlo), .data_word_high_reg(dhi));
  fsplc_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .ctrl_wr(ctrl_wr), .ctrl_wdata(wd),
    .ctrl_rdata(rd), .store_req(sreq), .store_ptr(sptr), .data_word_low_reg(dlo),
    .data_word_high_reg(dhi), .load_req(load_req), .load_ptr(lptr), .exec_pc(pc),
    .boot_start(16'h7000), .vectors_in_boot(vib), .chip_erase(ce), .ext_prog_req(1'b1),
    .ext_verify_req(1'b1), .ext_fuse_req(1'b1), .ext_boot_lock_req(1'b1),
    .store_blocked(sblk), .load_blocked(lblk), .rww_read_blocked(rrb), .cpu_stall(stall),
    .irq_mask(irqm), .ext_prog_refused(epr), .ext_verify_refused(evr), .ext_fuse_locked(efl),
    .ext_boot_lock_locked(ebl), .lock_byte_r(lb), .fuse_bytes_r(fuse), .flash_op_r(op),
    .flash_op_erase_r(ers), .flash_page_r(pg), .buf_rd_data_r(bufd), .buf_rd_idx(idx));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 3);
    seed = seed ^ (seed >> 5);
    seed = seed ^ (seed << 4);
    return seed;
  endfunction
  function automatic logic [7:0] expect_cmd(input logic [7:0] v);
    return (v[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) ? {3'h0, v[4:0]} : 8'h00;
  endfunction
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task cmd(input logic [7:0] v, input logic [15:0] ptr, input logic [15:0] w);
    wd = v;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
    m.store(ptr, w, 1'b1);
  endtask
  task wait_op();
    for (int k = 0; k < 500 && op !== 1'b1; k++) tick(1);
    chk("op", 1, op);
    tick(1);
  endtask
  task end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    tick(8);
    nrst = 1'b1;
    chk("ctrl", 8'h00, rd);
    chk("lock", 8'hff, lb);
    chk("fuse", 24'hffffff, fuse);
    // every legal code first, then random patterns, none followed by a store
    for (int i = 0; i < 45; i++) begin
      wd = (i < 5) ? cmds[i] : rnd();
      ctrl_wr = 1'b1;
      tick(1);
      ctrl_wr = 1'b0;
      chk("ctrl", expect_cmd(wd), rd & 8'h1f);
      tick(5);
      chk("lapse", 0, rd & 8'h1f);
    end
    wd = rnd();
    idx = wd[6:0];
    word = {rnd(), rnd()};
    cmd(8'h01, {8'h01, idx, 1'b1}, word);
    tick(1);
    chk("fill", word, bufd);
    chk("ctrl", 0, rd & 8'h1f);
    cmd(8'h03, 16'hff00, ~word);
    tick(3);
    chk("stall", 2'b11, {stall, rd[0]});
    chk("page", 10'h2ff, {ers, pg});
    wait_op();
    chk("ctrl", 0, rd & 8'h1f);
    cmd(8'h05, 16'h0100, word);
    tick(3);
    chk("busy", 9'h045, {stall, rd});
    chk("page", 10'h001, {ers, pg});
    wait_op();
    chk("ctrl", 0, rd & 8'h1f);
    cmd(8'h09, 16'hff00, 16'hfff3);
    tick(1);
    chk("lock", 8'hf3, lb);
    m.store(16'h0100, word, 1'b0);
    pc = 16'h7800;
    lptr = 16'h0100;
    load_req = 1'b1;
    tick(1);
    chk("blocks", 3'b111, {sblk, lblk, rrb});
    pc = 16'h0100;
    tick(1);
    chk("irq", 1, irqm);
    vib = 1'b0;
    tick(1);
    chk("irq", 0, irqm);
    load_req = 1'b0;
    cmd(8'h11, 16'h0000, word);
    tick(1);
    chk("busy", 0, rd[6]);
    cmd(8'h09, 16'hff00, 16'h00cc);
    tick(1);
    chk("ext", 12'hfc0, {epr, evr, efl, ebl, lb});
    pc = 16'h7800;
    tick(1);
    chk("irq", 1, irqm);
    cmd(8'h09, 16'hff00, 16'h00ff);
    tick(1);
    chk("lock", 8'hc0, lb);
    ce = 1'b1;
    tick(1);
    ce = 1'b0;
    tick(1);
    chk("lock", 8'hff, lb);
    end_of_test();
  end
endmodule
